// ---- design/power_mode_map.vh ----
// Register map, field positions, reset values and timing counts of the power-mode controller.
`ifndef POWER_MODE_MAP_VH
`define POWER_MODE_MAP_VH
// ==========================================================================
// Register word addresses (one step per register)
`define PM_ADDR_POWER_CTRL_FIRST  4'h0
`define PM_ADDR_POWER_CTRL_SECOND 4'h1
`define PM_ADDR_REGULATOR_CTRL    4'h2
`define PM_ADDR_CLOCK_CTRL        4'h3
`define PM_ADDR_TIMER_CTRL        4'h4
`define PM_ADDR_PERIPH_CLK_EN     4'h5
`define PM_ADDR_STATUS            4'h6
`define PM_ADDR_TIMER_COUNT       4'h7
// ==========================================================================
// Field positions
`define PM_BIT_IDLE          0
`define PM_BIT_STOP          1
`define PM_BIT_SUSPEND       0
`define PM_BIT_SNOOZE        1
`define PM_BIT_STOPCFG       0
`define PM_BIT_CLK_SRC_LO    0
`define PM_BIT_CLK_SRC_HI    1
`define PM_BIT_CLK_DIV_LO    2
`define PM_BIT_CLK_DIV_HI    4
`define PM_BIT_PRESCALE      5
`define PM_BIT_T3_SLOW       0
`define PM_BIT_T4_SLOW       1
`define PM_BIT_T_CHAIN       2
`define PM_BIT_T4_WAKE_EN    3
// ==========================================================================
// Clock sources
`define PM_SRC_FAST_A        2'h0
`define PM_SRC_FAST_B        2'h1
`define PM_SRC_EXT           2'h2
`define PM_SRC_SLOW          2'h3
// ==========================================================================
// Reset values
`define PM_RST_CLOCK_CTRL    8'h0c
`define PM_RST_PERIPH_CLK_EN 8'h00
`define PM_RST_TIMER_CTRL    8'h00
// ==========================================================================
// Timing counts
`define PM_SLOW_DIV          8
`define PM_OSC_START_NS      2000
`define PM_CLOCK_NS          25
`define PM_OSC_START_CYCLES  ((`PM_OSC_START_NS + `PM_CLOCK_NS - 1) / `PM_CLOCK_NS)
`endif

// ---- design/slow_tick_divider.v ----
// Divider that turns the synchronised slow-oscillator rising edges into a one-cycle tick every eighth rising edge.
`timescale 1ns/1ps
module slow_tick_divider #(
    parameter DIV = 8
) (
    // Clock and reset
    input  wire clock,
    input  wire sys_rst,
    // Synchronised slow oscillator level
    input  wire slow_level,
    // One-cycle tick out
    output reg  tick
);
    reg       last;
    reg [7:0] count;
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            last  <= 1'b0;
            count <= 8'h00;
            tick  <= 1'b0;
        end else begin
            last <= slow_level;
            tick <= 1'b0;
            if (slow_level && !last) begin
                if (count == DIV - 1) begin
                    count <= 8'h00;
                    tick  <= 1'b1;
                end else begin
                    count <= count + 8'h01;
                end
            end
        end
    end
endmodule

// ---- design/power_mode_controller.v ----
// Power-mode sequencer with clock gating, wake routing, clock divider setup and low-power timers.
//
// Contract
// - Idle bit halts core, peripherals stay clocked.
// - In Idle any interrupt wakes the core.
// - Suspend stops clocks, oscillators; normal regulator bias.
// - Snooze as Suspend but low regulator bias.
// - Timers three, four count from slow oscillator.
// - Slow oscillator divided by eight clocks timers.
// - Suspend and Snooze exit on listed wake events.
// - Execution resumes in place after wake.
// - Stop powers down; any reset ends it.
// - Shutdown ends only by pin or power-on reset.
// - Unused peripheral clocks are gated off.
// - Reset clock is first oscillator divided by eight.
// - Divider offers one through one hundred twenty-eight.
// - Each fast oscillator has a 1.5x prescaler.
// - Timer four wakes and chains with timer three.
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`include "power_mode_map.vh"
module power_mode_controller #(
    parameter NUM_PERIPH = 8,
    parameter OSC_START  = `PM_OSC_START_CYCLES
) (
    // Clock and reset
    input  wire        clock,
    input  wire        sys_rst,
    // Reset causes seen while powered down
    input  wire        reset_pin_n,
    input  wire        power_on_reset,
    input  wire        other_reset,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output reg         waitrequest,
    // Wake sources
    input  wire        any_interrupt,
    input  wire        serial_periph_port_wake,
    input  wire        two_wire_slave_port_wake,
    input  wire        port_match_wake,
    input  wire        comparator0_level,
    input  wire        config_logic_unit_wake,
    input  wire        slow_osc,
    // Power and clock controls
    output reg         core_clk_en,
    output reg  [NUM_PERIPH-1:0] periph_clk_en,
    output reg         fast_osc_a_en,
    output reg         fast_osc_b_en,
    output reg         regulator_low_bias,
    output reg         power_nets_off,
    output reg         pins_hold,
    output reg  [1:0]  system_clock_src,
    output reg  [2:0]  system_clock_div,
    output reg         prescale_1p5,
    output reg         timer3_tick,
    output reg         timer4_tick,
    output reg         reset_request
);
    // ======================================================================
    // States
    localparam [6:0] ST_NORMAL   = 7'h01;
    localparam [6:0] ST_IDLE     = 7'h02;
    localparam [6:0] ST_SUSPEND  = 7'h04;
    localparam [6:0] ST_SNOOZE   = 7'h08;
    localparam [6:0] ST_WAKE     = 7'h10;
    localparam [6:0] ST_STOP     = 7'h20;
    localparam [6:0] ST_SHUTDOWN = 7'h40;
    localparam [15:0] START_CNT  = OSC_START;

    reg [6:0]  state;
    reg [15:0] wake_count;
    reg [7:0]  clock_ctrl;
    reg [7:0]  timer_ctrl;
    reg [NUM_PERIPH-1:0] periph_en;
    reg        stop_cfg;
    reg [15:0] t4_count;
    reg [15:0] t3_count;
    reg        t4_event;

    // Wake pins, slow oscillator and reset pin pass two flip-flops; any_interrupt, power_on_reset and other_reset are read directly.
    reg [6:0] sync_a;
    reg [6:0] sync_b;
    wire [6:0] raw_in = {slow_osc, comparator0_level, config_logic_unit_wake, port_match_wake,
                         two_wire_slave_port_wake, serial_periph_port_wake, reset_pin_n};
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sync_a <= 7'h21;
            sync_b <= 7'h21;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end
    wire pin_n_s = sync_b[0];
    wire spi_s   = sync_b[1];
    wire i2c_s   = sync_b[2];
    wire pmatch_s = sync_b[3];
    wire clu_s   = sync_b[4];
    wire cmp_s   = sync_b[5];
    wire slow_s  = sync_b[6];
    reg  cmp_last;
    wire cmp_fall = cmp_last && !cmp_s;

    // ======================================================================
    // Slow tick: slow oscillator divided by eight.
    wire slow_tick;
    slow_tick_divider #(
        .DIV (`PM_SLOW_DIV)
    ) u_slow_div (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .slow_level (slow_s),
        .tick       (slow_tick)
    );

    // The deep modes keep this logic alive since it models always-on hardware.
    wire t3_tick_en = timer_ctrl[`PM_BIT_T3_SLOW] ? slow_tick : 1'b0;
    wire t4_base    = timer_ctrl[`PM_BIT_T4_SLOW] ? slow_tick : 1'b0;
    wire t4_tick_en = timer_ctrl[`PM_BIT_T_CHAIN] ? (t3_tick_en && t3_count == 16'hffff) : t4_base;

    function is_low_power;
        input [6:0] s;
        begin
            is_low_power = (s == ST_SUSPEND) || (s == ST_SNOOZE);
        end
    endfunction

    wire deep_wake = t4_event || spi_s || i2c_s || pmatch_s || cmp_fall || clu_s;

    // ======================================================================
    // Register bus: one wait cycle for every access. Read data is loaded in
    // the wait cycle so that it already stands when waitrequest falls.
    wire access = (read || write) && waitrequest;
    wire wr     = write && !waitrequest;
    wire rd     = read && waitrequest;
    wire w_first  = wr && address == `PM_ADDR_POWER_CTRL_FIRST;
    wire w_second = wr && address == `PM_ADDR_POWER_CTRL_SECOND;

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !access;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            clock_ctrl <= `PM_RST_CLOCK_CTRL;
            timer_ctrl <= `PM_RST_TIMER_CTRL;
            periph_en  <= {NUM_PERIPH{1'b0}};
            stop_cfg   <= 1'b0;
        end else if (wr) begin
            case (address)
                `PM_ADDR_REGULATOR_CTRL: begin
                    stop_cfg <= writedata[`PM_BIT_STOPCFG];
                end
                `PM_ADDR_CLOCK_CTRL: begin
                    clock_ctrl <= writedata[7:0];
                end
                `PM_ADDR_TIMER_CTRL: begin
                    timer_ctrl <= writedata[7:0];
                end
                `PM_ADDR_PERIPH_CLK_EN: begin
                    periph_en <= writedata[NUM_PERIPH-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            readdata <= 32'h00000000;
        end else if (rd) begin
            case (address)
                `PM_ADDR_POWER_CTRL_FIRST:  readdata <= {31'h0, state == ST_IDLE};
                `PM_ADDR_POWER_CTRL_SECOND: readdata <= {30'h0, state == ST_SNOOZE, state == ST_SUSPEND};
                `PM_ADDR_REGULATOR_CTRL:    readdata <= {31'h0, stop_cfg};
                `PM_ADDR_CLOCK_CTRL:        readdata <= {24'h0, clock_ctrl};
                `PM_ADDR_TIMER_CTRL:        readdata <= {24'h0, timer_ctrl};
                `PM_ADDR_PERIPH_CLK_EN:     readdata <= {{(32-NUM_PERIPH){1'b0}}, periph_en};
                `PM_ADDR_STATUS:            readdata <= {25'h0, state};
                `PM_ADDR_TIMER_COUNT:       readdata <= {t4_count, t3_count};
                default:                    readdata <= 32'h00000000;
            endcase
        end
    end

    // ======================================================================
    // Low-power timers; timer four overflow is the wake event.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            t3_count <= 16'h0000;
            t4_count <= 16'h0000;
            t4_event <= 1'b0;
            cmp_last <= 1'b1;
        end else begin
            cmp_last <= cmp_s;
            t4_event <= 1'b0;
            if (t3_tick_en) begin
                t3_count <= t3_count + 16'h0001;
            end
            if (t4_tick_en) begin
                t4_count <= t4_count + 16'h0001;
                if (t4_count == 16'hffff && timer_ctrl[`PM_BIT_T4_WAKE_EN]) begin
                    t4_event <= 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // Mode sequencer. Stop and Shutdown are only left through reset, so the
    // block raises a reset request instead of returning to Normal itself.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= ST_NORMAL;
            wake_count    <= 16'h0000;
            reset_request <= 1'b0;
        end else begin
            case (state)
                ST_NORMAL: begin
                    if (w_first && writedata[`PM_BIT_STOP]) begin
                        state <= stop_cfg ? ST_SHUTDOWN : ST_STOP;
                    end else if (w_first && writedata[`PM_BIT_IDLE]) begin
                        state <= ST_IDLE;
                    end else if (w_second && writedata[`PM_BIT_SUSPEND]) begin
                        state <= ST_SUSPEND;
                    end else if (w_second && writedata[`PM_BIT_SNOOZE]) begin
                        state <= ST_SNOOZE;
                    end
                end
                ST_IDLE: begin
                    if (any_interrupt) begin
                        state <= ST_NORMAL;
                    end
                end
                ST_SUSPEND, ST_SNOOZE: begin
                    if (deep_wake) begin
                        state      <= ST_WAKE;
                        wake_count <= START_CNT;
                    end
                end
                ST_WAKE: begin
                    if (wake_count <= 16'h0001) begin
                        state <= ST_NORMAL;
                    end else begin
                        wake_count <= wake_count - 16'h0001;
                    end
                end
                ST_STOP: begin
                    if (other_reset || power_on_reset || !pin_n_s) begin
                        reset_request <= 1'b1;
                    end
                end
                ST_SHUTDOWN: begin
                    if (power_on_reset || !pin_n_s) begin
                        reset_request <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_NORMAL;
                end
            endcase
        end
    end

    // ======================================================================
    // Registered power and clock controls.
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            core_clk_en        <= 1'b1;
            periph_clk_en      <= {NUM_PERIPH{1'b0}};
            fast_osc_a_en      <= 1'b1;
            fast_osc_b_en      <= 1'b0;
            regulator_low_bias <= 1'b0;
            power_nets_off     <= 1'b0;
            pins_hold          <= 1'b0;
            system_clock_src   <= `PM_SRC_FAST_A;
            system_clock_div   <= 3'h3;
            prescale_1p5       <= 1'b0;
            timer3_tick        <= 1'b0;
            timer4_tick        <= 1'b0;
        end else begin
            core_clk_en        <= (state == ST_NORMAL);
            periph_clk_en      <= (state == ST_NORMAL || state == ST_IDLE) ? periph_en
                                  : {NUM_PERIPH{1'b0}};
            fast_osc_a_en      <= !is_low_power(state) && state != ST_STOP && state != ST_SHUTDOWN;
            fast_osc_b_en      <= (state == ST_NORMAL || state == ST_IDLE)
                                  && clock_ctrl[`PM_BIT_CLK_SRC_HI:`PM_BIT_CLK_SRC_LO] == `PM_SRC_FAST_B;
            regulator_low_bias <= (state == ST_SNOOZE);
            power_nets_off     <= (state == ST_STOP || state == ST_SHUTDOWN);
            pins_hold          <= (state == ST_STOP || state == ST_SHUTDOWN);
            system_clock_src   <= clock_ctrl[`PM_BIT_CLK_SRC_HI:`PM_BIT_CLK_SRC_LO];
            system_clock_div   <= clock_ctrl[`PM_BIT_CLK_DIV_HI:`PM_BIT_CLK_DIV_LO];
            prescale_1p5       <= clock_ctrl[`PM_BIT_PRESCALE]
                                  && !clock_ctrl[`PM_BIT_CLK_SRC_HI];
            timer3_tick        <= t3_tick_en;
            timer4_tick        <= t4_tick_en;
        end
    end
endmodule

// ---- test/power_mode_checker_sva.sv ----
// Concurrent checks on the ports of the power-mode controller.
`timescale 1ns/1ps
module power_mode_checker #(
    parameter NUM_PERIPH = 8
) (
    // Clock and reset
    input wire                  clock,
    input wire                  sys_rst,
    // Reset causes
    input wire                  reset_pin_n,
    input wire                  power_on_reset,
    // Observed controls
    input wire                  core_clk_en,
    input wire [NUM_PERIPH-1:0] periph_clk_en,
    input wire                  fast_osc_a_en,
    input wire                  fast_osc_b_en,
    input wire                  regulator_low_bias,
    input wire                  power_nets_off,
    input wire                  pins_hold,
    input wire                  timer3_tick,
    input wire                  reset_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ==========================================================================
    // Checks
    a_osc_before_core: assert property (core_clk_en |-> fast_osc_a_en) else $error("core runs, osc off");
    a_sleep_gated: assert property (!fast_osc_a_en |-> !core_clk_en && periph_clk_en == 0 && !fast_osc_b_en)
        else $error("clocks live while asleep");
    a_low_bias_asleep: assert property (regulator_low_bias |-> !fast_osc_a_en) else $error("low bias awake");
    a_down_pins: assert property (power_nets_off |-> pins_hold && !core_clk_en) else $error("pins not held");
    a_por_exit: assert property (power_nets_off && power_on_reset |-> ##[1:4] reset_request)
        else $error("power-on reset ignored");
    a_pin_exit: assert property ((power_nets_off && !reset_pin_n) [*3] |-> ##[0:3] reset_request)
        else $error("reset pin ignored");
    a_request_holds: assert property (reset_request |=> reset_request) else $error("request dropped");
    a_request_cause: assert property ($rose(reset_request) |-> $past(power_nets_off))
        else $error("request while powered");
    a_tick_spacing: assert property (timer3_tick |=> !timer3_tick [*8]) else $error("ticks too close");
endmodule
bind power_mode_controller power_mode_checker #(.NUM_PERIPH(NUM_PERIPH)) chk_i (.clock, .sys_rst, .reset_pin_n,
    .power_on_reset, .core_clk_en, .periph_clk_en, .fast_osc_a_en, .fast_osc_b_en, .regulator_low_bias,
    .power_nets_off, .pins_hold, .timer3_tick, .reset_request);

// ---- test/tb_top.sv ----
// Self-checking bench for the power-mode controller.
`timescale 1ns/1ps
module tb_top;
    // ==========================================================================
    // Signals
    logic        clock, sys_rst, reset_pin_n, power_on_reset, other_reset, read, write, waitrequest;
    logic [3:0]  address;
    logic [31:0] writedata, readdata, rdv;
    logic        any_interrupt, serial_periph_port_wake, two_wire_slave_port_wake, port_match_wake;
    logic        comparator0_level, config_logic_unit_wake, slow_osc, core_clk_en, fast_osc_a_en;
    logic        fast_osc_b_en, regulator_low_bias, power_nets_off, pins_hold, prescale_1p5;
    logic        timer3_tick, timer4_tick, reset_request;
    logic [7:0]  periph_clk_en;
    logic [1:0]  system_clock_src, sdiv;
    logic [2:0]  system_clock_div;
    logic [13:0] rows [0:7];
    int          errors, cmp_count, n;
    // A short start-up count keeps each wake quick to simulate.
    power_mode_controller #(.NUM_PERIPH(8), .OSC_START(2)) dut (.clock, .sys_rst, .reset_pin_n, .power_on_reset,
        .other_reset, .address, .read, .write, .writedata, .readdata, .waitrequest, .any_interrupt,
        .serial_periph_port_wake, .two_wire_slave_port_wake, .port_match_wake, .comparator0_level,
        .config_logic_unit_wake, .slow_osc, .core_clk_en, .periph_clk_en, .fast_osc_a_en, .fast_osc_b_en,
        .regulator_low_bias, .power_nets_off, .pins_hold, .system_clock_src, .system_clock_div, .prescale_1p5,
        .timer3_tick, .timer4_tick, .reset_request);
    initial begin
        clock = 0;
        forever #12.5 clock = ~clock;
    end
    // Slow oscillator runs free, one edge every four clocks.
    always @(posedge clock) begin
        sdiv <= sdiv + 2'h1;
        if (sdiv == 2'h3) slow_osc <= ~slow_osc;
    end
    // ==========================================================================
    // Tasks
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic bail;
        errors++;
        $display("BAD wait expected done seen timeout");
        wrap_up();
    endtask
    task automatic settle(int c);
        repeat (c) @(posedge clock);
    endtask
    task automatic bus(logic wr, logic [3:0] a, logic [31:0] d);
        int k;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20) bail();
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic wait_core;
        for (n = 0; n < 60 && core_clk_en !== 1'b1; n++) @(posedge clock);
        if (n >= 60) bail();
        chk("osc a at resume", fast_osc_a_en, 1);
    endtask
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        settle(1);
    endtask
    task automatic power_down(logic [31:0] cfg);
        bus(1, 4'h2, cfg);
        bus(1, 4'h0, 32'h2);
        settle(3);
        chk("nets off", power_nets_off, 1);
        chk("pins hold", pins_hold, 1);
    endtask
    // ==========================================================================
    // Main sequence
    initial begin
        {sys_rst, reset_pin_n, comparator0_level} = 3'b111;
        {power_on_reset, other_reset, read, write, any_interrupt, slow_osc} = 6'h00;
        {serial_periph_port_wake, two_wire_slave_port_wake, port_match_wake, config_logic_unit_wake} = 4'h0;
        {address, writedata, sdiv} = 0;
        rows = '{{8'h00, 6'h00}, {8'h25, 6'h13}, {8'h0a, 6'h24}, {8'h2f, 6'h36},
                 {8'h30, 6'h09}, {8'h15, 6'h1a}, {8'h3a, 6'h2c}, {8'h1c, 6'h0e}};
        do_reset();
        chk("src", system_clock_src, 0);
        chk("div", system_clock_div, 3);
        bus(0, 4'h3, 0);
        chk("clock reg", rdv, 32'h0c);
        bus(0, 4'h8, 0);
        chk("unmapped", rdv, 0);
        foreach (rows[i]) begin
            bus(1, 4'h3, {24'h0, rows[i][13:6]});
            settle(3);
            chk("src", system_clock_src, rows[i][5:4]);
            chk("div", system_clock_div, rows[i][3:1]);
            chk("prescale", prescale_1p5, rows[i][0]);
            chk("osc b", fast_osc_b_en, rows[i][5:4] == 2'h1);
        end
        bus(1, 4'h4, 32'h3);
        for (n = 0; n < 200 && timer3_tick !== 1'b1; n++) @(posedge clock);
        @(posedge clock);
        for (n = 1; n < 200 && timer3_tick !== 1'b1; n++) @(posedge clock);
        chk("tick gap", n, 64);
        bus(1, 4'h5, 32'ha5);
        bus(1, 4'h0, 32'h1);
        settle(3);
        chk("core idle", core_clk_en, 0);
        chk("periph idle", periph_clk_en, 8'ha5);
        any_interrupt <= 1'b1;
        wait_core();
        any_interrupt <= 1'b0;
        bus(1, 4'h3, 32'h0c);
        for (int i = 0; i < 5; i++) begin
            bus(1, 4'h1, (i % 2) ? 32'h2 : 32'h1);
            settle(3);
            chk("osc a", fast_osc_a_en, 0);
            chk("bias", regulator_low_bias, i % 2);
            for (n = 0; n < 200 && timer4_tick !== 1'b1; n++) @(posedge clock);
            chk("tick asleep", n < 200, 1);
            case (i)
                0: serial_periph_port_wake <= 1'b1;
                1: two_wire_slave_port_wake <= 1'b1;
                2: port_match_wake <= 1'b1;
                3: config_logic_unit_wake <= 1'b1;
                default: comparator0_level <= 1'b0;
            endcase
            wait_core();
            {serial_periph_port_wake, two_wire_slave_port_wake, port_match_wake, config_logic_unit_wake} <= 4'h0;
            comparator0_level <= 1'b1;
            bus(0, 4'h6, 0);
            chk("status", rdv, 32'h1);
        end
        power_down(0);
        other_reset <= 1'b1;
        settle(4);
        chk("stop exit", reset_request, 1);
        other_reset <= 1'b0;
        do_reset();
        chk("request cleared", reset_request, 0);
        power_down(1);
        other_reset <= 1'b1;
        settle(4);
        chk("shutdown kept", reset_request, 0);
        other_reset <= 1'b0;
        reset_pin_n <= 1'b0;
        settle(6);
        chk("pin exit", reset_request, 1);
        reset_pin_n <= 1'b1;
        do_reset();
        power_down(1);
        power_on_reset <= 1'b1;
        settle(4);
        chk("por exit", reset_request, 1);
        power_on_reset <= 1'b0;
        wrap_up();
    end
    initial begin
        #2500000;
        bail();
    end
endmodule
